// File: shared/wcc_pkg.sv
// Package: constants and carrier types for the watchdog-clear / complement executor
// Summary of operation
// RL1 - Opcode 0x0004 forces the watchdog counter to zero.
// RL2 - The same opcode also clears the watchdog postscaler in that cycle.
// RL3 - Watchdog clear sets timeout and powerdown status bits; other flags untouched.
// RL4 - Opcode 0001 11da ffff ffff inverts the addressed byte, updating N and Z.
// RL5 - Destination bit 0 sends result to W; 1 writes it back to file.
// RL6 - Access bit 0 uses the access bank; 1 takes bank from bank select.
// RL7 - Extended set, access bit 0, address up to 0x5f: indexed literal offset.
// RL8 - Complement takes one cycle: decode Q1, read Q2, process Q3, write Q4.
package wcc_pkg;

    // ========================================================
    // Opcode fields
    localparam logic [15:0] WATCHDOG_CLEAR_OP_WORD    = 16'h0004;
    localparam logic [5:0]  COMPLEMENT_FILE_OP_PREFIX = 6'h07;
    localparam int          PREFIX_MSB                = 15;
    localparam int          PREFIX_LSB                = 10;
    localparam int          DEST_BIT                  = 9;
    localparam int          ACCESS_BIT                = 8;
    localparam logic [7:0]  LIT_OFFSET_LIMIT          = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT              = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BANK            = 4'hf;
    localparam logic [7:0]  ZERO_BYTE                 = 8'h00;

    // ========================================================
    // Quarter-cycle states
    typedef enum logic [3:0]
    {
        Q1 = 4'h1,
        Q2 = 4'h2,
        Q3 = 4'h4,
        Q4 = 4'h8
    } wcc_q_e;

    // Data memory write request
    typedef struct packed
    {
        logic        en;
        logic [11:0] addr;
        logic [7:0]  data;
    } wcc_wr_s;

    // Status flag update
    typedef struct packed
    {
        logic n_we;
        logic z_we;
        logic n;
        logic z;
    } wcc_flag_s;

endpackage

// File: hdl/wcc_addr_gen.sv
// Module: effective data address generation for byte-oriented file operands
module wcc_addr_gen
(
    input  wire logic [7:0]  i_file_addr,
    input  wire logic        i_access_sel,
    input  wire logic [3:0]  i_bank_select_reg,
    input  wire logic        i_ext_set_en,
    input  wire logic [11:0] i_index_base,
    output logic      [11:0] o_eff_addr
);

    // ========================================================
    // Address selection
    always_comb
    begin
        if (i_access_sel)
            o_eff_addr = {i_bank_select_reg, i_file_addr};                  // see RL6
        else if (i_ext_set_en && (i_file_addr <= wcc_pkg::LIT_OFFSET_LIMIT))
            // Index base plus offset wraps in 12 bits, like the data address space
            o_eff_addr = i_index_base + {4'h0, i_file_addr};                // see RL7
        else if (i_file_addr < wcc_pkg::ACCESS_SPLIT)
            o_eff_addr = {4'h0, i_file_addr};                               // see RL6
        else
            o_eff_addr = {wcc_pkg::ACCESS_HI_BANK, i_file_addr};
    end

endmodule

// File: hdl/wcc_exec.sv
// Module: execution of the watchdog clear and complement file instructions
module wcc_exec
(
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_valid,
    input  wire logic [15:0]       i_instr,
    input  wire logic [3:0]        i_bank_select_reg,
    input  wire logic              i_ext_set_en,
    input  wire logic [11:0]       i_index_base,
    input  wire logic [7:0]        i_rd_data,
    output logic                   o_q1,
    output logic      [11:0]       o_rd_addr,
    output logic                   o_rd_en,
    output wcc_pkg::wcc_wr_s       o_file_wr,
    output logic                   o_w_we,
    output logic      [7:0]        o_w_data,
    output wcc_pkg::wcc_flag_s     o_flags,
    output logic                   o_watchdog_counter_clr,
    output logic                   o_watchdog_post_clr,
    output logic                   o_timeout_status_bit_set,
    output logic                   o_powerdown_status_bit_set
);

    // ========================================================
    // Decode helpers
    function automatic logic is_complement_file_op(input logic [15:0] ins);
        is_complement_file_op = (ins[wcc_pkg::PREFIX_MSB:wcc_pkg::PREFIX_LSB]
                                 == wcc_pkg::COMPLEMENT_FILE_OP_PREFIX);
    endfunction

    function automatic logic is_watchdog_clear_op(input logic [15:0] ins);
        is_watchdog_clear_op = (ins == wcc_pkg::WATCHDOG_CLEAR_OP_WORD);
    endfunction

    // ========================================================
    // State
    wcc_pkg::wcc_q_e       q;
    wcc_pkg::wcc_q_e       next_q;
    logic [15:0]           ir;
    logic [15:0]           next_ir;
    logic [7:0]            opnd;
    logic [7:0]            next_opnd;
    logic [7:0]            res;
    logic [7:0]            next_res;
    logic [11:0]           eff_addr;
    logic                  do_complement;
    logic                  do_watchdog_clear;

    wcc_pkg::wcc_wr_s      next_file_wr;
    wcc_pkg::wcc_flag_s    next_flags;
    logic                  next_w_we;
    logic [7:0]            next_w_data;
    logic                  next_watchdog_clr;

    wcc_addr_gen u_addr
    (
        .i_file_addr       (ir[7:0]),
        .i_access_sel      (ir[wcc_pkg::ACCESS_BIT]),
        .i_bank_select_reg (i_bank_select_reg),
        .i_ext_set_en      (i_ext_set_en),
        .i_index_base      (i_index_base),
        .o_eff_addr        (eff_addr)
    );

    assign do_complement     = is_complement_file_op(ir);
    assign do_watchdog_clear = is_watchdog_clear_op(ir);
    assign o_q1              = (q == wcc_pkg::Q1);
    assign o_rd_addr         = eff_addr;
    assign o_rd_en           = (q == wcc_pkg::Q2) && do_complement;             // see RL8

    // ========================================================
    // Next-state logic
    always_comb
    begin
        next_ir      = ir;
        next_opnd    = opnd;
        next_res     = res;
        next_file_wr = '0;
        next_flags   = '0;
        next_w_we    = 1'b0;
        next_w_data  = o_w_data;
        next_watchdog_clr = 1'h0;
        case (q)
            wcc_pkg::Q1:
            begin
                next_q  = wcc_pkg::Q2;
                next_ir = i_valid ? i_instr : '0;                               // see RL8
            end
            wcc_pkg::Q2:
            begin
                next_q = wcc_pkg::Q3;
                if (do_complement)
                    next_opnd = i_rd_data;                                      // see RL8
            end
            wcc_pkg::Q3:
            begin
                next_q   = wcc_pkg::Q4;
                next_res = ~opnd;                                               // see RL4
                next_watchdog_clr = do_watchdog_clear;                          // see RL1
            end
            wcc_pkg::Q4:
            begin
                next_q = wcc_pkg::Q1;
                if (do_complement)
                begin
                    next_flags.n_we = 1'b1;                                     // see RL4
                    next_flags.z_we = 1'b1;
                    next_flags.n    = res[7];
                    next_flags.z    = (res == wcc_pkg::ZERO_BYTE);
                    if (ir[wcc_pkg::DEST_BIT])
                    begin
                        next_file_wr.en   = 1'b1;                               // see RL5
                        next_file_wr.addr = eff_addr;
                        next_file_wr.data = res;
                    end
                    else
                    begin
                        next_w_we   = 1'b1;                                     // see RL5
                        next_w_data = res;
                    end
                end
            end
            default:
            begin
                next_q = wcc_pkg::Q1;
            end
        endcase
    end

    // ========================================================
    // Registers
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q                          <= wcc_pkg::Q1;
            ir                         <= '0;
            opnd                       <= '0;
            res                        <= '0;
            o_file_wr                  <= '0;
            o_flags                    <= '0;
            o_w_we                     <= 1'b0;
            o_w_data                   <= '0;
            o_watchdog_counter_clr     <= 1'b0;
            o_watchdog_post_clr        <= 1'b0;
            o_timeout_status_bit_set   <= 1'b0;
            o_powerdown_status_bit_set <= 1'b0;
        end
        else
        begin
            q                          <= next_q;
            ir                         <= next_ir;
            opnd                       <= next_opnd;
            res                        <= next_res;
            o_file_wr                  <= next_file_wr;
            o_flags                    <= next_flags;
            o_w_we                     <= next_w_we;
            o_w_data                   <= next_w_data;
            // Counter and postscaler cleared together so the new period starts clean
            o_watchdog_counter_clr     <= next_watchdog_clr;                    // see RL1
            o_watchdog_post_clr        <= next_watchdog_clr;                    // see RL2
            o_timeout_status_bit_set   <= next_watchdog_clr;                    // see RL3
            o_powerdown_status_bit_set <= next_watchdog_clr;                    // see RL3
        end
    end

    // ========================================================
    // Checks
    sequence s_watchdog_clear_decoded;
        (q == wcc_pkg::Q3) && do_watchdog_clear;
    endsequence

    sequence s_complement_read;
        (q == wcc_pkg::Q2) && do_complement;
    endsequence

    chk_counter_clr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL1
        s_watchdog_clear_decoded |=> o_watchdog_counter_clr)
        else $error("watchdog counter clear missing");

    chk_postscaler_clr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL2
        o_watchdog_counter_clr == o_watchdog_post_clr)
        else $error("postscaler clear not with counter clear");

    chk_status_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL3
        o_timeout_status_bit_set |-> o_powerdown_status_bit_set && !o_flags.z_we && !o_flags.n_we)
        else $error("status bit set wrong");

    // The operand is the read byte sampled at the end of Q2, two edges before the flag update and three before the check
    chk_invert_flags: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL4
        s_complement_read |-> ##3 (o_flags.z_we && o_flags.n_we
            && (o_flags.n == (($past(i_rd_data, 3) & 8'h80) == 8'h00))
            && (o_flags.z == ($past(i_rd_data, 3) == 8'hff))))
        else $error("complement flags wrong");

    chk_invert_to_w: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL5
        s_complement_read ##0 !ir[wcc_pkg::DEST_BIT]
        |-> ##3 (o_w_we && (o_w_data == ~$past(i_rd_data, 3)) && !o_file_wr.en))
        else $error("complement to W wrong");

    chk_invert_to_file: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL5
        s_complement_read ##0 ir[wcc_pkg::DEST_BIT]
        |-> ##3 (o_file_wr.en && (o_file_wr.data == ~$past(i_rd_data, 3)) && !o_w_we))
        else $error("complement to file wrong");

    chk_bank_sel: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL6
        ir[wcc_pkg::ACCESS_BIT] |-> (eff_addr == {i_bank_select_reg, ir[7:0]}))
        else $error("banked address wrong");

    chk_lit_offset: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL7
        (!ir[wcc_pkg::ACCESS_BIT] && i_ext_set_en && ir[7:0] <= wcc_pkg::LIT_OFFSET_LIMIT)
        |-> (eff_addr == i_index_base + {4'h0, ir[7:0]}))
        else $error("indexed literal offset address wrong");

    chk_one_cycle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see RL8
        o_rd_en |=> (q == wcc_pkg::Q3) ##1 (q == wcc_pkg::Q4) ##1 (q == wcc_pkg::Q1))
        else $error("complement not finished in one instruction cycle");

endmodule

// File: sim/testbench.sv
// Self-checking testbench for the watchdog clear and complement file executor
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================================
    // Stimulus and observed signals
    logic               i_core_clk        = 1'b0;
    logic               i_rst_n           = 1'b0;
    logic               i_valid           = 1'b0;
    logic [15:0]        i_instr           = 16'h0000;
    logic [3:0]         i_bank_select_reg = 4'h0;
    logic               i_ext_set_en      = 1'b0;
    logic [11:0]        i_index_base      = 12'h000;
    logic [7:0]         i_rd_data         = 8'h00;
    logic               o_q1;
    logic [11:0]        o_rd_addr;
    logic               o_rd_en;
    wcc_pkg::wcc_wr_s   o_file_wr;
    logic               o_w_we;
    logic [7:0]         o_w_data;
    wcc_pkg::wcc_flag_s o_flags;
    logic [3:0]         wd;
    int                 errors     = 0;
    int                 num_checks = 0;

    always #25 i_core_clk = ~i_core_clk;

    wcc_exec dut_u
    (
        .i_core_clk                 (i_core_clk),
        .i_rst_n                    (i_rst_n),
        .i_valid                    (i_valid),
        .i_instr                    (i_instr),
        .i_bank_select_reg          (i_bank_select_reg),
        .i_ext_set_en               (i_ext_set_en),
        .i_index_base               (i_index_base),
        .i_rd_data                  (i_rd_data),
        .o_q1                       (o_q1),
        .o_rd_addr                  (o_rd_addr),
        .o_rd_en                    (o_rd_en),
        .o_file_wr                  (o_file_wr),
        .o_w_we                     (o_w_we),
        .o_w_data                   (o_w_data),
        .o_flags                    (o_flags),
        .o_watchdog_counter_clr     (wd[3]),
        .o_watchdog_post_clr        (wd[2]),
        .o_timeout_status_bit_set   (wd[1]),
        .o_powerdown_status_bit_set (wd[0])
    );

    // ========================================================
    // Shared helpers
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict;
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Access bank splits at 0x60; literal offset wraps in 12 bits
    function automatic logic [11:0] exp_addr(input logic [15:0] ins);
        if (ins[8])
            return {i_bank_select_reg, ins[7:0]};
        if (i_ext_set_en && ins[7:0] <= 8'h5f)
            return i_index_base + {4'h0, ins[7:0]};
        return {(ins[7:0] < 8'h60) ? 4'h0 : 4'hf, ins[7:0]};
    endfunction

    // One instruction cycle; leaves the bench at the next Q1 so calls run back to back
    task automatic run(input logic v, input logic [15:0] ins, input logic [7:0] rd);
        logic        cpl;
        logic        clr;
        logic        d;
        logic [11:0] a;
        logic [7:0]  res;
        int          n;
        n = 0;
        while (o_q1 !== 1'b1 && n < 8)
        begin
            @(negedge i_core_clk);
            n++;
        end
        check("q1_ready", 1, o_q1);
        cpl = v && ins[15:10] == 6'h07;
        clr = v && ins == 16'h0004;
        d = ins[9];
        a = exp_addr(ins);
        res = ~rd;
        i_valid = v;
        i_instr = ins;
        i_rd_data = rd;
        @(negedge i_core_clk);
        // A watchdog clear shown outside Q1 must be ignored
        i_valid = 1'b1;
        i_instr = 16'h0004;
        check("rd_en", cpl, o_rd_en);
        if (cpl) check("rd_addr", a, o_rd_addr);
        @(negedge i_core_clk);
        i_valid = 1'b0;
        i_rd_data = ~rd;
        check("q3_pulses", 0, wd);
        @(negedge i_core_clk);
        check("wdt_pulses", {4{clr}}, wd);
        check("q4_file_en", 0, o_file_wr.en);
        @(negedge i_core_clk);
        check("wdt_pulse_end", 0, wd);
        check("file_en", cpl && d, o_file_wr.en);
        if (cpl && d) check("file_word", {a, res}, {o_file_wr.addr, o_file_wr.data});
        check("w_we", cpl && !d, o_w_we);
        if (cpl && !d) check("w_data", res, o_w_data);
        check("flag_we", {cpl, cpl}, {o_flags.n_we, o_flags.z_we});
        if (cpl) check("flag_nz", {res[7], res == 8'h00}, {o_flags.n, o_flags.z});
    endtask

    // ========================================================
    // Scenarios
    task automatic test_wdt_clear;
        run(1'b1, 16'h0004, 8'h00);
        run(1'b1, 16'h0005, 8'h00);
        run(1'b0, 16'h0004, 8'h00);
    endtask

    task automatic test_complement_dest;
        run(1'b1, 16'h1c13, 8'h13);
        run(1'b1, 16'h1e80, 8'hff);
        run(1'b1, 16'h1e20, 8'h00);
        run(1'b1, 16'h1c22, 8'h7e);
    endtask

    task automatic test_complement_bank;
        i_bank_select_reg = 4'h5;
        i_index_base = 12'hffe;
        run(1'b1, 16'h1f80, 8'h5a);
        run(1'b1, 16'h1e5f, 8'h01);
        run(1'b1, 16'h1e60, 8'h02);
        i_ext_set_en = 1'b1;
        run(1'b1, 16'h1e05, 8'h03);
        run(1'b1, 16'h1c5f, 8'h04);
        run(1'b1, 16'h1e60, 8'h05);
        run(1'b1, 16'h1f10, 8'h06);
        i_ext_set_en = 1'b0;
    endtask

    // Reset in mid-instruction must drop the pending write-back
    task automatic test_reset_abort;
        while (o_q1 !== 1'b1) @(negedge i_core_clk);
        i_valid = 1'b1;
        i_instr = 16'h1e40;
        @(negedge i_core_clk);
        i_valid = 1'b0;
        i_rst_n = 1'b0;
        @(negedge i_core_clk);
        check("rst_outputs", 0, {o_file_wr.en, o_w_we, o_flags, wd, o_rd_en});
        check("rst_q1", 1, o_q1);
        i_rst_n = 1'b1;
        run(1'b1, 16'h0004, 8'h00);
    endtask

    // ========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (12) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        test_wdt_clear();
        test_complement_dest();
        test_complement_bank();
        test_reset_abort();
        print_verdict();
    end

    initial
    begin
        #(50 * 2000);
        errors++;
        print_verdict();
    end
endmodule
